// >>> rtl/ctad_regs.svh
`ifndef CTAD_REGS_SVH
`define CTAD_REGS_SVH
// Operand specifier byte layout.
`define CTAD_MODE_HI 7
`define CTAD_MODE_LO 6
`define CTAD_REG_HI 5
`define CTAD_REG_LO 3
`define CTAD_RM_HI 2
`define CTAD_RM_LO 0
`define CTAD_MODE_NODISP 2'h0
`define CTAD_MODE_DISP8 2'h1
`define CTAD_MODE_DISP16 2'h2
`define CTAD_MODE_REG 2'h3
`define CTAD_RM_DIRECT 3'h6
// Operation selectors in the register field and in the arithmetic rows.
`define CTAD_SEL_ADD 3'h0
`define CTAD_SEL_ONE 3'h1
`define CTAD_SEL_ADC 3'h2
`define CTAD_SEL_BORROW 3'h3
`define CTAD_SEL_SUB 3'h5
`define CTAD_SEL_PUSH 3'h6
`define CTAD_SEL_COMPARE 3'h7
// Opcodes.
`define CTAD_OPC_IMM_B 8'h80
`define CTAD_OPC_IMM_W 8'h81
`define CTAD_OPC_IMM_SX 8'h83
`define CTAD_OPC_MOVI_B 8'hC6
`define CTAD_OPC_MOVI_W 8'hC7
`define CTAD_OPC_SEG_ST 8'h8C
`define CTAD_OPC_SEG_LD 8'h8E
`define CTAD_OPC_GRP_B 8'hFE
`define CTAD_OPC_GRP_W 8'hFF
`define CTAD_OPC_FLG_ST 8'h9C
`define CTAD_OPC_FLG_LD 8'h9D
`define CTAD_OPC_LOOKUP 8'hD7
`define CTAD_OPC_ASC_SUM 8'h37
`define CTAD_OPC_BCD_SUM 8'h27
`define CTAD_OPC_ASC_DIF 8'h3F
`define CTAD_OPC_BCD_DIF 8'h2F
`define CTAD_OPC_ASC_MUL 8'hD4
`define CTAD_ASC_MUL_2ND 8'h0A
`define CTAD_OPC_B_WIDEN 8'h98
`define CTAD_OPC_W_WIDEN 8'h99
`define CTAD_ROW_INC 5'h08
`define CTAD_ROW_DEC 5'h09
`define CTAD_ROW_SWAP 5'h12
`define CTAD_ROW_PORT_FIX 6'h39
`define CTAD_ROW_PORT_IND 6'h3B
`define CTAD_PFX_HI 3'h1
`define CTAD_PFX_LO 3'h6
// Cycle counts.
`define CTAD_CYC_SEG_REG 8'h02
`define CTAD_CYC_SEG_ST 8'h09
`define CTAD_CYC_SEG_LD 8'h08
`define CTAD_CYC_MOVI 8'h0A
`define CTAD_CYC_PUSH_MEM 8'h10
`define CTAD_CYC_FLG_ST 8'h0A
`define CTAD_CYC_FLG_LD 8'h08
`define CTAD_CYC_SWAP 8'h03
`define CTAD_CYC_PORT_FIX 8'h0A
`define CTAD_CYC_PORT_IND 8'h08
`define CTAD_CYC_LOOKUP 8'h0B
`define CTAD_CYC_ALU_REG 8'h03
`define CTAD_CYC_ALU_LD 8'h09
`define CTAD_CYC_ALU_ST 8'h10
`define CTAD_CYC_ALU_ACC 8'h04
`define CTAD_CYC_IMM_REG 8'h04
`define CTAD_CYC_IMM_MEM 8'h11
`define CTAD_CYC_IMM_COMPARE 8'h0A
`define CTAD_CYC_INC_W 8'h02
`define CTAD_CYC_INC_B 8'h03
`define CTAD_CYC_INC_MEM 8'h0F
`define CTAD_CYC_SUM_FIX 8'h04
`define CTAD_CYC_ASC_DIF 8'h08
`define CTAD_CYC_BCD_DIF 8'h04
`define CTAD_CYC_ASC_MUL 8'h53
`define CTAD_CYC_B_WIDEN 8'h02
`define CTAD_CYC_W_WIDEN 8'h05
// Operand location time.
`define CTAD_EA_OVR 8'h02
`define CTAD_EA_DIRECT 8'h06
`define CTAD_EA_PAIR_A 8'h07
`define CTAD_EA_PAIR_B 8'h08
`define CTAD_EA_PAIR_A_D 8'h0B
`define CTAD_EA_PAIR_B_D 8'h0C
`define CTAD_EA_ONE 8'h05
`define CTAD_EA_ONE_D 8'h09
`endif

// >>> rtl/ctad_pkg.sv
package ctad_pkg;
  typedef enum logic [4:0] {
    op_none, transfer_op, seg_to_gp_op, gp_to_seg_op, push_mem_op,
    flags_stack_store_op, flags_stack_load_op, swap_op, port_in_op, port_out_op,
    table_lookup_op, sum_op, sum_with_carry_op, difference_op,
    difference_with_borrow_op, compare_op, plus_one_op, minus_one_op,
    ascii_sum_fix_op, bcd_sum_fix_op, ascii_diff_fix_op, bcd_diff_fix_op,
    ascii_product_fix_op, byte_widen_op, word_widen_op
  } ctad_op_t;
  typedef enum logic [2:0] {st_opc, st_mrm, st_disp, st_imm, st_emit} ctad_state_t;
  typedef struct packed {
    ctad_op_t op;
    logic wide;
    logic mem;
    logic [1:0] mode;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic seg_ovr;
    logic port_indirect;
    logic use_carry;
    logic store;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [7:0] cycles;
  } ctad_instr_t;
  typedef struct packed {
    logic ok;
    ctad_op_t op;
    logic has_mrm;
    logic [1:0] imm_len;
    logic sext;
    logic wide;
    logic use_carry;
    logic store;
    logic port_indirect;
    logic [7:0] cyc_reg;
    logic [7:0] cyc_mem;
  } ctad_info_t;
  typedef struct packed {
    ctad_state_t st;
    logic [7:0] opc;
    logic [7:0] mrm;
    logic seg_ovr;
    logic [1:0] disp_left;
    logic [1:0] imm_left;
    logic disp_hi;
    logic imm_hi;
    logic [15:0] disp;
    logic [15:0] imm;
    ctad_instr_t out;
    logic out_valid;
    logic bad;
  } ctad_dec_q_t;
  typedef struct packed {
    logic [7:0] cnt;
  } ctad_timer_q_t;
endpackage

// >>> rtl/ctad_ea_time.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctad_regs.svh"
module ctad_ea_time (
  input wire logic [1:0] mode_in, // Mode field of the operand specifier.
  input wire logic [2:0] rm_in,   // Register/memory field.
  input wire logic seg_ovr_in,    // Segment override prefix seen.
  output logic [7:0] ea_out       // Operand location time in cycles.
);
  logic [7:0] base;
  always_comb begin
    base = 8'h00;
    if (mode_in == `CTAD_MODE_NODISP) begin
      case (rm_in)
        3'h0, 3'h3: base = `CTAD_EA_PAIR_A;
        3'h1, 3'h2: base = `CTAD_EA_PAIR_B;
        `CTAD_RM_DIRECT: base = `CTAD_EA_DIRECT;
        default: base = `CTAD_EA_ONE;
      endcase
    end else if (mode_in != `CTAD_MODE_REG) begin
      case (rm_in)
        3'h0, 3'h3: base = `CTAD_EA_PAIR_A_D;
        3'h1, 3'h2: base = `CTAD_EA_PAIR_B_D;
        default: base = `CTAD_EA_ONE_D;
      endcase
    end
    // A register operand has no location time, so the prefix adds nothing there.
    if (mode_in != `CTAD_MODE_REG && seg_ovr_in) begin
      ea_out = 8'(base + `CTAD_EA_OVR);
    end else begin
      ea_out = base;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ctad_cycle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ctad_cycle_timer
  import ctad_pkg::*;
(
  input wire logic mclk_in,          // Processor clock.
  input wire logic resetn_in,        // Asynchronous reset, active low.
  input wire logic load_in,          // Start an execution interval.
  input wire logic [7:0] count_in,   // Length of the interval in cycles.
  output logic busy_out              // High while the interval runs.
);
  ctad_timer_q_t q, d;
  always_comb begin
    d = q;
    if (load_in) begin
      d.cnt = count_in;
    end else if (q.cnt != 8'h00) begin
      d.cnt = 8'(q.cnt - 8'h01);
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign busy_out = (q.cnt != 8'h00);
  a_timer_counts_down: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    load_in && count_in == 8'h02 |=> busy_out ##1 busy_out ##1 !busy_out)
    else $error("Timer interval length wrong.");
endmodule
`default_nettype wire

// >>> rtl/ctad_decoder.sv
// Notes on behaviour
// - C6/C7 with register field 000 store an immediate; 10 cycles plus location time.
// - 8C copies segment to general word register, 8E back; register form 2 cycles.
// - 8C to memory takes 9 plus location time; 8E from memory 8 plus.
// - FF with field 110 pushes a memory word, stack pointer minus 2; 16 plus.
// - 9C pushes the flags word, stack pointer minus 2, in 10 cycles.
// - 9D pops the flags word, stack pointer plus 2, in 8 cycles.
// - 90 plus register swaps word accumulator with that register in 3 cycles.
// - E4/E5 read the port named by the next byte; 10 cycles.
// - EC/ED read the port held in the data word register; 8 cycles.
// - E6/E7 write the accumulator to the port in the next byte; 10 cycles.
// - EE/EF write the accumulator to the data word register port; 8 cycles.
// - D7 replaces the byte accumulator from a translation table in 11 cycles.
// - Add with carry: 1x row forms, immediate forms with field 010.
// - Subtract with borrow: 1x row forms, immediate forms with field 011.
// - Compare subtracts for flags only; 3A/3B register forms take 3 cycles.
// - 40 plus register increments a word in 2; FE field 000 byte in 3.
// - 48 plus register decrements a word in 2; FE/FF field 001 decrement.
// - 80, 81, 83 immediates; field 000 add, 101 subtract, 111 compare.
// - 37 and 27 adjust the byte accumulator after addition in 4 cycles.
// - 3F adjusts after subtraction in 8 cycles, 2F in 4 cycles.
// - D4 0A adjusts the word accumulator after multiply in 83 cycles.
// - 98 widens byte to word in 2 cycles; 99 word to pair in 5.
// - Specifier byte: mode bits 7-6, register 5-3, register/memory 2-0.
// - Location time grows by 2 with a prefix; displacement-only is 6.
`timescale 1ns/10ps
`default_nettype none
`include "ctad_regs.svh"
module ctad_decoder
  import ctad_pkg::*;
(
  input wire logic mclk_in,               // Processor clock, 100 MHz.
  input wire logic resetn_in,             // Asynchronous reset, active low.
  input wire logic [7:0] byte_in,         // Instruction stream byte.
  input wire logic byte_valid_in,         // Stream byte present.
  output logic byte_ready_out,            // Decoder takes the byte this cycle.
  output ctad_pkg::ctad_instr_t instr_out, // Decoded instruction.
  output logic instr_valid_out,           // One-cycle pulse with instr_out.
  output logic unknown_out,               // One-cycle pulse on a rejected opcode.
  output logic busy_out                   // Execution interval running.
);
  import ctad_pkg::*;

  ctad_dec_q_t q, d;
  ctad_info_t inf_b;
  ctad_info_t inf_q;
  logic take;
  logic prefix;
  logic [1:0] disp_len;
  logic [7:0] ea;
  logic [7:0] total;
  logic second_ok;
  logic timer_load;

  function automatic ctad_op_t alu_map(input logic [2:0] s);
    ctad_op_t o;
    case (s)
      `CTAD_SEL_ADD: o = sum_op;
      `CTAD_SEL_ADC: o = sum_with_carry_op;
      `CTAD_SEL_BORROW: o = difference_with_borrow_op;
      `CTAD_SEL_SUB: o = difference_op;
      `CTAD_SEL_COMPARE: o = compare_op;
      default: o = op_none;
    endcase
    return o;
  endfunction

  // Opcode-only fields (lengths) are valid from the opcode alone; the rest
  // needs the specifier byte as well.
  function automatic ctad_info_t classify(input logic [7:0] o, input logic [7:0] m);
    ctad_info_t i;
    logic [2:0] r;
    i = '0;
    r = m[`CTAD_REG_HI:`CTAD_REG_LO];
    i.wide = o[0];
    i.store = 1'b1;
    if (o[7:6] == 2'h0 && o[2:1] != 2'h3 && alu_map(o[5:3]) != op_none) begin
      i.op = alu_map(o[5:3]);
      i.ok = 1'b1;
      i.use_carry = (o[5:3] == `CTAD_SEL_ADC) || (o[5:3] == `CTAD_SEL_BORROW);
      i.store = (i.op != compare_op);
      if (!o[2]) begin
        i.has_mrm = 1'b1;
        i.cyc_reg = `CTAD_CYC_ALU_REG;
        i.cyc_mem = (o[1] || i.op == compare_op) ? `CTAD_CYC_ALU_LD : `CTAD_CYC_ALU_ST;
      end else begin
        i.imm_len = o[0] ? 2'h2 : 2'h1;
        i.cyc_reg = `CTAD_CYC_ALU_ACC;
        i.cyc_mem = `CTAD_CYC_ALU_ACC;
      end
    end else begin
      case (o)
        `CTAD_OPC_IMM_B, `CTAD_OPC_IMM_W, `CTAD_OPC_IMM_SX: begin
          i.has_mrm = 1'b1;
          i.imm_len = (o == `CTAD_OPC_IMM_W) ? 2'h2 : 2'h1;
          i.sext = (o == `CTAD_OPC_IMM_SX);
          i.op = alu_map(r);
          i.ok = (i.op != op_none);
          i.use_carry = (r == `CTAD_SEL_ADC) || (r == `CTAD_SEL_BORROW);
          i.store = (i.op != compare_op);
          i.cyc_reg = `CTAD_CYC_IMM_REG;
          i.cyc_mem = (i.op == compare_op) ? `CTAD_CYC_IMM_COMPARE : `CTAD_CYC_IMM_MEM;
        end
        `CTAD_OPC_MOVI_B, `CTAD_OPC_MOVI_W: begin
          i.has_mrm = 1'b1;
          i.imm_len = o[0] ? 2'h2 : 2'h1;
          i.op = transfer_op;
          i.ok = (r == `CTAD_SEL_ADD);
          i.cyc_reg = `CTAD_CYC_MOVI;
          i.cyc_mem = `CTAD_CYC_MOVI;
        end
        `CTAD_OPC_SEG_ST, `CTAD_OPC_SEG_LD: begin
          i.has_mrm = 1'b1;
          i.wide = 1'b1;
          i.ok = 1'b1;
          i.op = (o == `CTAD_OPC_SEG_ST) ? seg_to_gp_op : gp_to_seg_op;
          i.cyc_reg = `CTAD_CYC_SEG_REG;
          i.cyc_mem = (o == `CTAD_OPC_SEG_ST) ? `CTAD_CYC_SEG_ST : `CTAD_CYC_SEG_LD;
        end
        `CTAD_OPC_GRP_B, `CTAD_OPC_GRP_W: begin
          i.has_mrm = 1'b1;
          i.cyc_reg = `CTAD_CYC_INC_B;
          i.cyc_mem = `CTAD_CYC_INC_MEM;
          if (r == `CTAD_SEL_ADD) begin
            i.op = plus_one_op;
            i.ok = 1'b1;
          end else if (r == `CTAD_SEL_ONE) begin
            i.op = minus_one_op;
            i.ok = 1'b1;
          end else if (r == `CTAD_SEL_PUSH && o == `CTAD_OPC_GRP_W) begin
            i.op = push_mem_op;
            i.ok = 1'b1;
            i.cyc_reg = `CTAD_CYC_PUSH_MEM;
            i.cyc_mem = `CTAD_CYC_PUSH_MEM;
          end
        end
        `CTAD_OPC_FLG_ST: begin
          i.op = flags_stack_store_op;
          i.ok = 1'b1;
          i.cyc_reg = `CTAD_CYC_FLG_ST;
        end
        `CTAD_OPC_FLG_LD: begin
          i.op = flags_stack_load_op;
          i.ok = 1'b1;
          i.cyc_reg = `CTAD_CYC_FLG_LD;
        end
        `CTAD_OPC_LOOKUP: begin
          i.op = table_lookup_op;
          i.ok = 1'b1;
          i.wide = 1'b0;
          i.cyc_reg = `CTAD_CYC_LOOKUP;
        end
        `CTAD_OPC_ASC_SUM, `CTAD_OPC_BCD_SUM: begin
          i.op = (o == `CTAD_OPC_ASC_SUM) ? ascii_sum_fix_op : bcd_sum_fix_op;
          i.ok = 1'b1;
          i.wide = 1'b0;
          i.cyc_reg = `CTAD_CYC_SUM_FIX;
        end
        `CTAD_OPC_ASC_DIF, `CTAD_OPC_BCD_DIF: begin
          i.op = (o == `CTAD_OPC_ASC_DIF) ? ascii_diff_fix_op : bcd_diff_fix_op;
          i.ok = 1'b1;
          i.wide = 1'b0;
          i.cyc_reg = (o == `CTAD_OPC_ASC_DIF) ? `CTAD_CYC_ASC_DIF : `CTAD_CYC_BCD_DIF;
        end
        `CTAD_OPC_ASC_MUL: begin
          i.op = ascii_product_fix_op;
          i.ok = 1'b1;
          i.wide = 1'b1;
          i.imm_len = 2'h1;
          i.cyc_reg = `CTAD_CYC_ASC_MUL;
        end
        `CTAD_OPC_B_WIDEN, `CTAD_OPC_W_WIDEN: begin
          i.op = (o == `CTAD_OPC_B_WIDEN) ? byte_widen_op : word_widen_op;
          i.ok = 1'b1;
          i.cyc_reg = (o == `CTAD_OPC_B_WIDEN) ? `CTAD_CYC_B_WIDEN : `CTAD_CYC_W_WIDEN;
        end
        default: begin
          if (o[7:3] == `CTAD_ROW_INC || o[7:3] == `CTAD_ROW_DEC) begin
            i.op = (o[7:3] == `CTAD_ROW_INC) ? plus_one_op : minus_one_op;
            i.ok = 1'b1;
            i.wide = 1'b1;
            i.cyc_reg = `CTAD_CYC_INC_W;
          end else if (o[7:3] == `CTAD_ROW_SWAP) begin
            i.op = swap_op;
            i.ok = 1'b1;
            i.wide = 1'b1;
            i.cyc_reg = `CTAD_CYC_SWAP;
          end else if (o[7:2] == `CTAD_ROW_PORT_FIX) begin
            i.op = o[1] ? port_out_op : port_in_op;
            i.ok = 1'b1;
            i.imm_len = 2'h1;
            i.cyc_reg = `CTAD_CYC_PORT_FIX;
          end else if (o[7:2] == `CTAD_ROW_PORT_IND) begin
            i.op = o[1] ? port_out_op : port_in_op;
            i.ok = 1'b1;
            i.port_indirect = 1'b1;
            i.cyc_reg = `CTAD_CYC_PORT_IND;
          end
        end
      endcase
    end
    if (!i.has_mrm) begin
      i.cyc_mem = i.cyc_reg;
    end
    return i;
  endfunction

  assign inf_b = classify(byte_in, 8'h00);
  assign inf_q = classify(q.opc, q.mrm);
  assign take = byte_valid_in && byte_ready_out;
  assign prefix = (byte_in[7:5] == `CTAD_PFX_HI) && (byte_in[2:0] == `CTAD_PFX_LO);
  assign second_ok = (q.opc != `CTAD_OPC_ASC_MUL) || (q.imm[7:0] == `CTAD_ASC_MUL_2ND);

  always_comb begin
    case (byte_in[`CTAD_MODE_HI:`CTAD_MODE_LO])
      `CTAD_MODE_DISP8: disp_len = 2'h1;
      `CTAD_MODE_DISP16: disp_len = 2'h2;
      `CTAD_MODE_NODISP: disp_len = (byte_in[`CTAD_RM_HI:`CTAD_RM_LO] == `CTAD_RM_DIRECT) ? 2'h2 : 2'h0;
      default: disp_len = 2'h0;
    endcase
  end

  ctad_ea_time u_ea (
    .mode_in(q.mrm[`CTAD_MODE_HI:`CTAD_MODE_LO]),
    .rm_in(q.mrm[`CTAD_RM_HI:`CTAD_RM_LO]),
    .seg_ovr_in(q.seg_ovr),
    .ea_out(ea)
  );

  // Register form: base count only; memory form adds the location time.
  assign total = (inf_q.has_mrm && q.mrm[`CTAD_MODE_HI:`CTAD_MODE_LO] != `CTAD_MODE_REG) ?
                 8'(inf_q.cyc_mem + ea) : inf_q.cyc_reg;
  assign timer_load = (q.st == st_emit) && inf_q.ok && second_ok;

  always_comb begin
    d = q;
    d.out_valid = 1'b0;
    d.bad = 1'b0;
    case (q.st)
      st_opc: begin
        if (take && prefix) begin
          d.seg_ovr = 1'b1;
        end else if (take) begin
          d.opc = byte_in;
          d.mrm = 8'h00;
          d.disp = 16'h0000;
          d.imm = 16'h0000;
          d.disp_hi = 1'b0;
          d.imm_hi = 1'b0;
          d.disp_left = 2'h0;
          d.imm_left = inf_b.imm_len;
          if (!inf_b.ok && !inf_b.has_mrm) begin
            d.bad = 1'b1;
            d.seg_ovr = 1'b0;
          end else if (inf_b.has_mrm) begin
            d.st = st_mrm;
          end else if (inf_b.imm_len != 2'h0) begin
            d.st = st_imm;
          end else begin
            d.st = st_emit;
          end
        end
      end
      st_mrm: begin
        if (take) begin
          d.mrm = byte_in;
          d.disp_left = disp_len;
          if (disp_len != 2'h0) begin
            d.st = st_disp;
          end else if (q.imm_left != 2'h0) begin
            d.st = st_imm;
          end else begin
            d.st = st_emit;
          end
        end
      end
      st_disp: begin
        if (take) begin
          d.disp_hi = 1'b1;
          d.disp_left = 2'(q.disp_left - 2'h1);
          if (q.disp_hi) begin
            d.disp[15:8] = byte_in;
          end else begin
            d.disp = {{8{byte_in[7]}}, byte_in};
          end
          if (q.disp_left == 2'h1) begin
            d.st = (q.imm_left != 2'h0) ? st_imm : st_emit;
          end
        end
      end
      st_imm: begin
        if (take) begin
          d.imm_hi = 1'b1;
          d.imm_left = 2'(q.imm_left - 2'h1);
          if (q.imm_hi) begin
            d.imm[15:8] = byte_in;
          end else begin
            d.imm = {(inf_q.sext ? {8{byte_in[7]}} : 8'h00), byte_in};
          end
          if (q.imm_left == 2'h1) begin
            d.st = st_emit;
          end
        end
      end
      st_emit: begin
        d.st = st_opc;
        d.seg_ovr = 1'b0;
        if (timer_load) begin
          d.out_valid = 1'b1;
          d.out.op = inf_q.op;
          d.out.wide = inf_q.wide;
          d.out.mode = q.mrm[`CTAD_MODE_HI:`CTAD_MODE_LO];
          d.out.mem = inf_q.has_mrm && (q.mrm[`CTAD_MODE_HI:`CTAD_MODE_LO] != `CTAD_MODE_REG);
          d.out.reg_f = q.mrm[`CTAD_REG_HI:`CTAD_REG_LO];
          d.out.rm = inf_q.has_mrm ? q.mrm[`CTAD_RM_HI:`CTAD_RM_LO] : q.opc[2:0];
          d.out.seg_ovr = q.seg_ovr;
          d.out.port_indirect = inf_q.port_indirect;
          d.out.use_carry = inf_q.use_carry;
          d.out.store = inf_q.store;
          d.out.disp = q.disp;
          d.out.imm = q.imm;
          d.out.cycles = total;
        end else begin
          d.bad = 1'b1;
        end
      end
      default: d.st = st_opc;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Stream is held off until the previous instruction's cycle count has run out.
  ctad_cycle_timer u_timer (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .load_in(timer_load),
    .count_in(total),
    .busy_out(busy_out)
  );

  assign byte_ready_out = (q.st != st_emit) && !busy_out;
  assign instr_out = q.out;
  assign instr_valid_out = q.out_valid;
  assign unknown_out = q.bad;

  a_flag_store_time: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == flags_stack_store_op |-> instr_out.cycles == 8'h0A)
    else $error("Flags store cycle count wrong.");
  a_flag_load_time: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == flags_stack_load_op |-> instr_out.cycles == 8'h08)
    else $error("Flags load cycle count wrong.");
  a_swap_time: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == swap_op |-> instr_out.cycles == 8'h03 && instr_out.wide)
    else $error("Swap decode wrong.");
  a_compare_no_store: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == compare_op |-> !instr_out.store)
    else $error("Compare would store its result.");
  a_sext_imm: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && q.opc == `CTAD_OPC_IMM_SX |-> instr_out.imm[15:8] == {8{instr_out.imm[7]}})
    else $error("Short immediate not sign extended.");
  a_product_fix_time: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == ascii_product_fix_op |-> instr_out.cycles == 8'h53)
    else $error("Multiply adjust cycle count wrong.");
  a_override_adds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == push_mem_op && instr_out.seg_ovr && instr_out.mode == 2'h0 &&
    instr_out.rm == 3'h6 |-> instr_out.cycles == 8'h18)
    else $error("Location time with prefix wrong.");
  a_busy_holds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out && instr_out.op == word_widen_op |-> busy_out [*5] ##1 !busy_out)
    else $error("Execution interval length wrong.");
  a_carry_use: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_out |-> instr_out.use_carry ==
    (instr_out.op inside {sum_with_carry_op, difference_with_borrow_op}))
    else $error("Carry use flag wrong.");
endmodule
`default_nettype wire

// >>> verification/ctad_src.sv
`timescale 1ns/10ps
`default_nettype none
module ctad_src (
  input wire logic mclk_in, // Processor clock.
  input wire logic ready_in, // Byte taken.
  output logic [7:0] byte_out, // Stream byte.
  output logic valid_out // Byte present.
);
  logic [7:0] q[$];
  logic [7:0] last_q = 8'h00;
  initial valid_out = 1'b0;
  initial byte_out = 8'hFF;
  // Between bytes the line shows the inverse of the last byte.
  always @(posedge mclk_in) begin
    if (valid_out && ready_in) begin
      last_q = q.pop_front();
    end
    #1;
    valid_out = (q.size() != 0);
    byte_out = valid_out ? q[0] : ~last_q;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s %0h %0h", nm, e, g); end end
module tb;
  import ctad_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] byte_in;
  logic byte_valid_in, byte_ready_out, instr_valid_out, unknown_out, busy_out;
  ctad_instr_t instr_out;
  int n_fail = 0, checks = 0, cyc_n = 0;
  ctad_decoder ctad_decoder_inst (.mclk_in(mclk_in), .resetn_in(resetn_in), .byte_in(byte_in),
    .byte_valid_in(byte_valid_in), .byte_ready_out(byte_ready_out), .instr_out(instr_out),
    .instr_valid_out(instr_valid_out), .unknown_out(unknown_out), .busy_out(busy_out));
  ctad_src ctad_src_inst (.mclk_in(mclk_in), .ready_in(byte_ready_out), .byte_out(byte_in), .valid_out(byte_valid_in));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic tick;
    @(posedge mclk_in);
    #2;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic x(input logic [47:0] b, input int n, input ctad_op_t op, input logic [7:0] cyc);
    int i;
    for (i = 0; i < n; i++) ctad_src_inst.q.push_back(b[8*i+:8]);
    for (i = 0; i < 100 && instr_valid_out !== 1'b1; i++) tick;
    `CHK("op", op, instr_out.op)
    `CHK("cycles", cyc, instr_out.cycles)
    for (i = 0; i < 300 && busy_out === 1'b1; i++) tick;
    `CHK("busy", cyc, i[7:0])
  endtask
  task automatic t_xfer;
    x(48'h551234_06C626,6,transfer_op,8'h12);
    x(48'hC08C,2,seg_to_gp_op,8'h02);
    x(48'h048C,2,seg_to_gp_op,8'h0E);
    x(48'h1F8E,2,gp_to_seg_op,8'h0D);
    `CHK("fields", 8'h1F, {instr_out.mode, instr_out.reg_f, instr_out.rm})
    x(48'h200036FF,4,push_mem_op,8'h16);
    x(48'h200036FF2E,5,push_mem_op,8'h18);
    `CHK("disp", 16'h2000, instr_out.disp)
    x(48'h9C,1,flags_stack_store_op,8'h0A);
    x(48'h9D,1,flags_stack_load_op,8'h08);
    x(48'h93,1,swap_op,8'h03);
    x(48'h80E4,2,port_in_op,8'h0A);
    `CHK("port", 16'h0080, instr_out.imm)
    x(48'hED,1,port_in_op,8'h08);
    `CHK("indirect", 1'b1, instr_out.port_indirect)
    x(48'h80E7,2,port_out_op,8'h0A);
    x(48'hEE,1,port_out_op,8'h08);
    x(48'hD7,1,table_lookup_op,8'h0B);
    $display("test xfer done");
  endtask
  task automatic t_arith;
    x(48'hC112,2,sum_with_carry_op,8'h03);
    x(48'hC11B,2,difference_with_borrow_op,8'h03);
    x(48'hC13A,2,compare_op,8'h03);
    x(48'h47,1,plus_one_op,8'h02);
    x(48'hC0FE,2,plus_one_op,8'h03);
    x(48'h804703,3,sum_op,8'h12);
    `CHK("disp8", 16'hFF80, instr_out.disp)
    x(48'h10000EFF,4,minus_one_op,8'h15);
    x(48'h05E880,3,difference_op,8'h04);
    x(48'h05F880,3,compare_op,8'h04);
    x(48'h80C083,3,sum_op,8'h04);
    `CHK("imm", 16'hFF80, instr_out.imm)
    $display("test arith done");
  endtask
  task automatic t_misc;
    int i;
    x(48'h37,1,ascii_sum_fix_op,8'h04);
    x(48'h27,1,bcd_sum_fix_op,8'h04);
    x(48'h3F,1,ascii_diff_fix_op,8'h08);
    x(48'h2F,1,bcd_diff_fix_op,8'h04);
    x(48'h0AD4,2,ascii_product_fix_op,8'h53);
    x(48'h98,1,byte_widen_op,8'h02);
    x(48'h99,1,word_widen_op,8'h05);
    ctad_src_inst.q = '{8'h80, 8'hC8, 8'h05};
    for (i = 0; i < 20 && unknown_out !== 1'b1; i++) tick;
    `CHK("unknown", 1'b1, unknown_out)
    tick;
    ctad_src_inst.q = '{8'hD4, 8'h0B};
    for (i = 0; i < 20 && unknown_out !== 1'b1; i++) tick;
    `CHK("unknown2", 1'b1, unknown_out)
    $display("test misc done");
  endtask
  always @(posedge mclk_in) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    tick;
    t_xfer;
    t_arith;
    t_misc;
    end_sim;
  end
endmodule
`default_nettype wire
